// ### rpc_cmd_handler.sv
`timescale 1ns/1ps
module rpc_cmd_handler #(
   parameter logic [rpc_pkg::CNT_W-1:0] RETRY_CYC  = rpc_pkg::RETRY_CYC,
   parameter logic [rpc_pkg::CNT_W-1:0] WINDOW_CYC = rpc_pkg::WINDOW_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        lk_clk,
   input  wire logic        lk_srst,
   input  wire logic        lk_req,
   input  wire logic        lk_wr,
   input  wire logic        lk_side,
   input  wire logic [7:0]  lk_cmd,
   input  wire logic [15:0] lk_wdata,
   output logic             lk_busy,
   output logic             lk_done,
   output logic             lk_nack,
   output logic [15:0]      lk_rdata,
   input  wire logic        hw_on_in,
   input  wire logic        ov_trip_in,
   input  wire logic [7:0]  fault_in,
   input  wire logic        ctrl_side_in,
   input  wire logic        low_line_in,
   input  wire logic [15:0] vprog_in,
   output logic             main_on,
   output logic [15:0]      vout_target,
   output logic [7:0]       fan_duty,
   output logic             fan_override,
   output logic             latched_off,
   output logic [1:0]       alert
);

   ////////////////////////////////////////////////////////////////////////////////
   // Link-side state: holds one transaction while the system side works on it.
   typedef struct packed {
      logic        busy;
      logic        req_tgl;
      logic        done_s1;
      logic        done_s2;
      logic        done_seen;
      logic        wr;
      logic        side;
      logic [7:0]  cmd;
      logic [15:0] wdata;
      logic        done;
      logic        nack;
      logic [15:0] rdata;
   } rpc_lk_t;

   // System-side state: synchronisers, settings, status and the retry machine.
   typedef struct packed {
      logic                                 req_s1;
      logic                                 req_s2;
      logic                                 req_seen;
      logic                                 done_tgl;
      logic                                 nack;
      logic [15:0]                          rdata;
      logic [1:0]                           hw_on_s;
      logic [1:0]                           trip_s;
      logic [1:0]                           side_s;
      logic [1:0]                           ll_s;
      logic [7:0]                           flt_s1;
      logic [7:0]                           flt_s2;
      logic [15:0]                          vp_s1;
      logic [15:0]                          vp_s2;
      logic                                 trip_prev;
      logic                                 main_q;
      logic                                 op_on;
      logic [7:0]                           guard;
      logic                                 bus_vout;
      logic [rpc_pkg::NSLOT-1:0][15:0]      val;
      logic [rpc_pkg::NSLOT-1:0][15:0]      usr;
      logic [7:0]                           flags;
      logic [7:0]                           comm;
      logic [1:0]                           alert;
      rpc_pkg::rpc_ov_t                     ov;
      logic [1:0]                           restarts;
      logic                                 win_run;
      logic [rpc_pkg::CNT_W-1:0]            tmr;
      logic [rpc_pkg::CNT_W-1:0]            win;
      logic [15:0]                          vtgt;
   } rpc_sys_t;

   rpc_lk_t  lk_q;
   rpc_lk_t  lk_d;
   rpc_sys_t sy_q;
   rpc_sys_t sy_d;

   // Reset image of the system side: output on, guard open, factory settings.
   function automatic rpc_sys_t sys_reset();
      rpc_sys_t r;
      r       = '0;
      r.op_on = 1'b1;
      r.guard = rpc_pkg::GUARD_NONE;
      r.val   = rpc_pkg::SLOT_DEF;
      r.usr   = rpc_pkg::SLOT_DEF;
      r.ov    = rpc_pkg::OV_RUN;
      return r;
   endfunction

   localparam rpc_sys_t SYS_RST = sys_reset();

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: take a request when idle, toggle it across, wait for the answer toggle.
   always_comb begin
      lk_d         = lk_q;
      lk_d.done_s1 = sy_q.done_tgl;
      lk_d.done_s2 = lk_q.done_s1;
      lk_d.done    = 1'b0;
      if (!lk_q.busy && lk_req) begin
         lk_d.busy    = 1'b1;
         lk_d.req_tgl = ~lk_q.req_tgl;
         lk_d.wr      = lk_wr;
         lk_d.side    = lk_side;
         lk_d.cmd     = lk_cmd;
         lk_d.wdata   = lk_wdata;
      end else if (lk_q.busy && (lk_q.done_s2 != lk_q.done_seen)) begin
         // The system side holds its answer until the next request, so it is stable here.
         lk_d.done_seen = lk_q.done_s2;
         lk_d.busy      = 1'b0;
         lk_d.done      = 1'b1;
         lk_d.nack      = sy_q.nack;
         lk_d.rdata     = sy_q.rdata;
      end
   end

   // Link-domain registers.
   always_ff @(posedge lk_clk) begin
      if (lk_srst) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Finds the setting slot that belongs to a command code.
   function automatic logic [4:0] find_slot(input logic [7:0] code);
      logic [4:0] res;
      res = '0;
      for (int i = 0; i < rpc_pkg::NSLOT; i++) begin
         if (rpc_pkg::SLOT_CODE[i] == code) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // System domain: command execution, status flags and the overvoltage retry machine.
   always_comb begin
      logic        run_on;
      logic        trip_rise;
      logic        restart_ok;
      logic        clr;
      logic        bad_cmd;
      logic        bad_data;
      logic        refused;
      logic [4:0]  hit;
      logic [4:0]  uhit;
      logic [7:0]  dbyte;
      logic [15:0] rd;
      logic [7:0]  fresh;
      sy_d       = sy_q;
      run_on     = 1'b0;
      trip_rise  = 1'b0;
      restart_ok = 1'b0;
      clr        = 1'b0;
      bad_cmd    = 1'b0;
      bad_data   = 1'b0;
      refused    = 1'b0;
      hit        = find_slot(lk_q.cmd);
      uhit       = find_slot(lk_q.wdata[7:0]);
      dbyte      = lk_q.wdata[7:0];
      rd         = '0;
      fresh      = '0;

      // Two-stage synchronisers for the request toggle and all pins.
      sy_d.req_s1  = lk_q.req_tgl;
      sy_d.req_s2  = sy_q.req_s1;
      sy_d.hw_on_s = {sy_q.hw_on_s[0], hw_on_in};
      sy_d.trip_s  = {sy_q.trip_s[0], ov_trip_in};
      sy_d.side_s  = {sy_q.side_s[0], ctrl_side_in};
      sy_d.ll_s    = {sy_q.ll_s[0], low_line_in};
      sy_d.flt_s1  = fault_in;
      sy_d.flt_s2  = sy_q.flt_s1;
      sy_d.vp_s1   = vprog_in;
      sy_d.vp_s2   = sy_q.vp_s1;

      // Output runs only when commanded on, enabled by the pin and not tripped.
      run_on          = sy_q.op_on && sy_q.hw_on_s[1] && (sy_q.ov == rpc_pkg::OV_RUN);
      trip_rise       = sy_q.trip_s[1] && !sy_q.trip_prev;
      restart_ok      = run_on && !sy_q.main_q;
      sy_d.trip_prev  = sy_q.trip_s[1];
      sy_d.main_q     = run_on;

      // One transaction per request toggle; the answer toggle goes back when done.
      if (sy_q.req_s2 != sy_q.req_seen) begin
         sy_d.req_seen = sy_q.req_s2;
         sy_d.done_tgl = ~sy_q.done_tgl;
         if (lk_q.wr) begin
            if (lk_q.cmd == rpc_pkg::CMD_CLR_FAULTS) begin
               clr = (lk_q.side == sy_q.side_s[1]);
            end else if (lk_q.cmd == rpc_pkg::CMD_WR_GUARD) begin
               // The guard itself is always writable.
               if (dbyte == rpc_pkg::GUARD_NONE || dbyte == rpc_pkg::GUARD_ALL ||
                   dbyte == rpc_pkg::GUARD_KEEP_ONOF) begin
                  sy_d.guard = dbyte;
               end else begin
                  bad_data = 1'b1;
               end
            end else if (sy_q.guard != rpc_pkg::GUARD_NONE &&
                         !(sy_q.guard == rpc_pkg::GUARD_KEEP_ONOF && lk_q.cmd == rpc_pkg::CMD_ON_OFF)) begin
               refused = 1'b1;
            end else if (lk_q.cmd == rpc_pkg::CMD_ON_OFF) begin
               if (dbyte == rpc_pkg::ON_OFF_ON) begin
                  sy_d.op_on = 1'b1;
               end else if (dbyte == rpc_pkg::ON_OFF_OFF) begin
                  sy_d.op_on = 1'b0;
               end else begin
                  bad_data = 1'b1;
               end
            end else if (lk_q.cmd == rpc_pkg::CMD_RESTORE_FAC) begin
               sy_d.val = rpc_pkg::SLOT_DEF;
            end else if (lk_q.cmd == rpc_pkg::CMD_RESTORE_UA) begin
               sy_d.val = sy_q.usr;
            end else if (lk_q.cmd == rpc_pkg::CMD_STORE_USER) begin
               // Only setting slots have user defaults, so the guard is never saved.
               if (uhit[4]) begin
                  sy_d.usr[uhit[3:0]] = sy_q.val[uhit[3:0]];
               end else begin
                  bad_data = 1'b1;
               end
            end else if (lk_q.cmd == rpc_pkg::CMD_RESTORE_U1) begin
               if (uhit[4]) begin
                  sy_d.val[uhit[3:0]] = sy_q.usr[uhit[3:0]];
               end else begin
                  bad_data = 1'b1;
               end
            end else if (hit[4]) begin
               // Values outside the adjustment range leave the setting untouched.
               if (lk_q.wdata >= rpc_pkg::SLOT_LO[hit[3:0]] && lk_q.wdata <= rpc_pkg::SLOT_HI[hit[3:0]]) begin
                  sy_d.val[hit[3:0]] = lk_q.wdata;
                  if (hit[3:0] == 4'(rpc_pkg::SLOT_VOUT)) begin
                     sy_d.bus_vout = 1'b1;
                  end
               end else begin
                  bad_data = 1'b1;
               end
            end else begin
               bad_cmd = 1'b1;
            end
         end else begin
            // Reads are never subject to the write guard.
            if (lk_q.cmd == rpc_pkg::CMD_ON_OFF) begin
               rd = {8'h00, sy_q.op_on ? rpc_pkg::ON_OFF_ON : rpc_pkg::ON_OFF_OFF};
            end else if (lk_q.cmd == rpc_pkg::CMD_WR_GUARD) begin
               rd = {8'h00, sy_q.guard};
            end else if (lk_q.cmd == rpc_pkg::CMD_VOUT_FMT) begin
               rd = {8'h00, rpc_pkg::VOUT_FMT_VAL};
            end else if (lk_q.cmd == rpc_pkg::CMD_VIN_TURN_ON) begin
               rd = sy_q.ll_s[1] ? rpc_pkg::VIN_ON_LL : rpc_pkg::VIN_ON_HL;
            end else if (lk_q.cmd == rpc_pkg::CMD_VIN_TURN_OF) begin
               rd = sy_q.ll_s[1] ? rpc_pkg::VIN_OFF_LL : rpc_pkg::VIN_OFF_HL;
            end else if (lk_q.cmd == rpc_pkg::CMD_FAN_SETUP) begin
               rd = {8'h00, rpc_pkg::FAN_SETUP_VAL};
            end else if (lk_q.cmd == rpc_pkg::CMD_OV_REACTION) begin
               rd = {8'h00, rpc_pkg::OV_REACTION_VAL};
            end else if (lk_q.cmd == rpc_pkg::CMD_STAT_SUMM) begin
               rd = {8'h00, sy_q.flags};
            end else if (lk_q.cmd == rpc_pkg::CMD_STAT_COMM) begin
               rd = {8'h00, sy_q.comm};
            end else if (hit[4]) begin
               rd = sy_q.val[hit[3:0]];
            end else begin
               bad_cmd = 1'b1;
            end
         end
         sy_d.rdata = rd;
         sy_d.nack  = bad_cmd || bad_data || refused;
      end

      // Communication status: cleared by a valid clear, then set by this transaction's errors.
      if (clr || restart_ok) begin
         sy_d.comm = '0;
      end
      if (bad_data) begin
         sy_d.comm[rpc_pkg::COMM_BAD_DATA] = 1'b1;
      end
      if (bad_cmd) begin
         sy_d.comm[rpc_pkg::COMM_BAD_CMD] = 1'b1;
      end
      if (refused) begin
         sy_d.comm[rpc_pkg::COMM_OTHER] = 1'b1;
      end

      // Fault flags latch the pins; a clear empties them for one cycle and a live fault returns.
      fresh = sy_q.flt_s2 & ~sy_q.flags;
      if (clr || restart_ok) begin
         sy_d.flags = '0;
      end else begin
         sy_d.flags = sy_q.flags | sy_q.flt_s2;
      end

      // Alerts: a clear releases only the controlling side; a new fault sets both and wins.
      if (clr) begin
         sy_d.alert[sy_q.side_s[1]] = 1'b0;
      end
      if (restart_ok) begin
         sy_d.alert = '0;
      end
      if (|fresh) begin
         sy_d.alert = 2'b11;
      end

      // One-minute window: retries forgotten when it runs out.
      if (sy_q.win_run) begin
         sy_d.win = sy_q.win + 1'b1;
         if (sy_q.win == WINDOW_CYC - 1'b1) begin
            sy_d.win_run  = 1'b0;
            sy_d.restarts = '0;
         end
      end

      // Overvoltage retry machine.
      case (sy_q.ov)
         rpc_pkg::OV_RUN: begin
            if (trip_rise && run_on) begin
               sy_d.tmr = '0;
               if (!sy_q.win_run) begin
                  sy_d.win_run  = 1'b1;
                  sy_d.win      = '0;
               end
               if (sy_q.restarts == rpc_pkg::RETRY_MAX && sy_q.win_run) begin
                  sy_d.ov = rpc_pkg::OV_LATCH;
               end else begin
                  sy_d.ov = rpc_pkg::OV_WAIT;
               end
            end
         end
         rpc_pkg::OV_WAIT: begin
            sy_d.tmr = sy_q.tmr + 1'b1;
            if (sy_q.tmr == RETRY_CYC - 1'b1) begin
               sy_d.ov       = rpc_pkg::OV_RUN;
               sy_d.restarts = sy_q.restarts + 1'b1;
            end
         end
         rpc_pkg::OV_LATCH: begin
            // Turning off by pin or bus releases the latch; turning on again restarts.
            if (!sy_q.op_on || !sy_q.hw_on_s[1]) begin
               sy_d.ov       = rpc_pkg::OV_RUN;
               sy_d.restarts = '0;
               sy_d.win_run  = 1'b0;
            end
         end
         default: begin
            sy_d.ov = rpc_pkg::OV_RUN;
         end
      endcase

      // Setpoint follows the program pin until a bus write takes over.
      sy_d.vtgt = sy_q.bus_vout ? sy_q.val[rpc_pkg::SLOT_VOUT] : sy_q.vp_s2;
   end

   // System-domain registers; reset stands for loss of controller power.
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sy_q <= SYS_RST;
      end else begin
         sy_q <= sy_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from registers.
   assign lk_busy      = lk_q.busy;
   assign lk_done      = lk_q.done;
   assign lk_nack      = lk_q.nack;
   assign lk_rdata     = lk_q.rdata;
   assign main_on      = sy_q.main_q;
   assign vout_target  = sy_q.vtgt;
   assign fan_duty     = sy_q.val[rpc_pkg::SLOT_FAN][7:0];
   assign fan_override = (sy_q.val[rpc_pkg::SLOT_FAN][7:0] != rpc_pkg::FAN_INTERNAL);
   assign latched_off  = (sy_q.ov == rpc_pkg::OV_LATCH);
   assign alert        = sy_q.alert;

endmodule

// ### rpc_cmd_handler_monitor.sv
`timescale 1ns/1ps
// Watches the link answer timing and the output controls of the handler.
module rpc_cmd_handler_monitor (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic       lk_clk,
   input wire logic       lk_srst,
   input wire logic       lk_req,
   input wire logic       lk_busy,
   input wire logic       lk_done,
   input wire logic       lk_nack,
   input wire logic       hw_on_in,
   input wire logic       ov_trip_in,
   input wire logic       main_on,
   input wire logic [7:0] fan_duty,
   input wire logic       fan_override,
   input wire logic       latched_off
);
   ////////////////////////////////////////////////////////////////////////////////
   // Link side checks.
   a_done_one_pulse: assert property (@(posedge lk_clk) disable iff (lk_srst) lk_done |=> !lk_done)
      else $error("answer strobe longer than one cycle");
   a_answer_bound: assert property (@(posedge lk_clk) disable iff (lk_srst) (lk_req && !lk_busy) |-> ##[1:20] lk_done)
      else $error("request not answered in time");
   a_nack_on_done: assert property (@(posedge lk_clk) disable iff (lk_srst) $changed(lk_nack) |-> lk_done)
      else $error("refusal flag moved outside an answer");
   ////////////////////////////////////////////////////////////////////////////////
   // Output control checks.
   a_latch_keeps_off: assert property (@(posedge clk_sys) disable iff (srst) latched_off |=> !main_on)
      else $error("output running while latched off");
   a_fan_flag_match: assert property (@(posedge clk_sys) disable iff (srst) fan_override == (fan_duty != 8'h00))
      else $error("fan override flag disagrees with duty");
   a_duty_limit: assert property (@(posedge clk_sys) disable iff (srst) fan_duty <= 8'h64)
      else $error("fan duty above full scale");
   a_pin_turns_off: assert property (@(posedge clk_sys) disable iff (srst) (!hw_on_in) [*4] |-> !main_on)
      else $error("output running with the on pin low");
   a_trip_stops_run: assert property (@(posedge clk_sys) disable iff (srst) ($rose(ov_trip_in) && main_on) |-> ##[1:6] !main_on)
      else $error("overvoltage trip did not stop the output");
   // Main scenarios reached.
   c_latch: cover property (@(posedge clk_sys) disable iff (srst) $rose(latched_off));
   c_refused: cover property (@(posedge lk_clk) disable iff (lk_srst) lk_done && lk_nack);
   c_fan: cover property (@(posedge clk_sys) disable iff (srst) $rose(fan_override));
endmodule

bind rpc_cmd_handler rpc_cmd_handler_monitor mon_u (.clk_sys(clk_sys), .srst(srst), .lk_clk(lk_clk),
   .lk_srst(lk_srst), .lk_req(lk_req), .lk_busy(lk_busy), .lk_done(lk_done), .lk_nack(lk_nack),
   .hw_on_in(hw_on_in), .ov_trip_in(ov_trip_in), .main_on(main_on), .fan_duty(fan_duty),
   .fan_override(fan_override), .latched_off(latched_off));

// ### rpc_cmd_handler_tb_top.sv
`timescale 1ns/1ps
// Runs the command table, then the fault clear, setpoint, fan, retry and reset cases.
module rpc_cmd_handler_tb_top;
   logic        clk_sys, srst, lk_clk, lk_srst, lk_req, lk_wr, lk_side, lk_busy, lk_done, lk_nack, nk;
   logic        hw_on_in, ov_trip_in, ctrl_side_in, low_line_in, main_on, fan_override, latched_off;
   logic [1:0]  alert;
   logic [7:0]  lk_cmd, fan_duty;
   logic [15:0] lk_wdata, lk_rdata, vout_target, rd;
   logic [7:0]  fault_in = 8'h00;
   logic [15:0] vprog_in = 16'h6A00;
   int          errors = 0;
   int          n_tests = 0;
   // Row: side, write, refused, spare bit; command; data sent; data expected.
   logic [43:0] rows [38] = '{44'h0_20_0000_0017, 44'h0_3A_0000_0000, 44'h0_41_0000_0080, 44'h0_35_0000_0384,
      44'h0_36_0000_0320, 44'h0_10_0000_0000, 44'h0_21_0000_6C00, 44'h6_01_0055_0000, 44'h4_01_0080_0000,
      44'h6_3B_0065_0000, 44'h6_21_5000_0000, 44'h0_21_0000_6C00, 44'h0_7E_0000_0040, 44'hC_03_0000_0000,
      44'h0_7E_0000_0040, 44'h4_03_0000_0000, 44'h0_7E_0000_0000, 44'h4_10_0080_0000, 44'h6_21_6000_0000,
      44'h6_01_0000_0000, 44'h0_21_0000_6C00, 44'h4_10_0040_0000, 44'h4_01_0000_0000, 44'h4_01_0080_0000,
      44'h6_21_6000_0000, 44'h4_10_0000_0000, 44'h6_10_0022_0000, 44'h4_21_64E6_0000, 44'h4_17_0021_0000,
      44'h6_17_0010_0000, 44'h4_21_6000_0000, 44'h4_18_0021_0000, 44'h0_21_0000_64E6, 44'h4_12_0000_0000,
      44'h0_21_0000_6C00, 44'h4_16_0000_0000, 44'h0_21_0000_64E6, 44'h2_99_0000_0000};
   rpc_cmd_handler #(.RETRY_CYC(34'd20), .WINDOW_CYC(34'd200)) dut_u (.clk_sys(clk_sys), .srst(srst),
      .lk_clk(lk_clk), .lk_srst(lk_srst), .lk_req(lk_req), .lk_wr(lk_wr), .lk_side(lk_side), .lk_cmd(lk_cmd),
      .lk_wdata(lk_wdata), .lk_busy(lk_busy), .lk_done(lk_done), .lk_nack(lk_nack), .lk_rdata(lk_rdata),
      .hw_on_in(hw_on_in), .ov_trip_in(ov_trip_in), .fault_in(fault_in), .ctrl_side_in(ctrl_side_in),
      .low_line_in(low_line_in), .vprog_in(vprog_in), .main_on(main_on), .vout_target(vout_target),
      .fan_duty(fan_duty), .fan_override(fan_override), .latched_off(latched_off), .alert(alert));
   rpc_host_model host_u (.lk_clk(lk_clk), .lk_done(lk_done), .lk_nack(lk_nack), .lk_rdata(lk_rdata),
      .lk_req(lk_req), .lk_wr(lk_wr), .lk_side(lk_side), .lk_cmd(lk_cmd), .lk_wdata(lk_wdata));
   // Two unrelated clocks.
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      lk_clk = 1'b0;
      #1.3;
      forever #7.5 lk_clk = ~lk_clk;
   end
   // Waits whole system cycles and lands just after an edge.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One overvoltage pulse, then a bounded wait for the restart.
   task automatic trip();
      int n;
      n = 0;
      ov_trip_in = 1'b1;
      cyc(6);
      ov_trip_in = 1'b0;
      while (main_on !== 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
   // Main sequence.
   initial begin
      {srst, lk_srst, hw_on_in, ov_trip_in, ctrl_side_in, low_line_in} = 6'b111000;
      cyc(2);
      srst = 1'b0;
      @(posedge lk_clk);
      #1 lk_srst = 1'b0;
      cyc(8);
      chk("on after power up", 16'h0001, {15'h0, main_on});
      chk("pin setpoint", 16'h6A00, vout_target);
      $display("test reset done");
      foreach (rows[i]) begin
         host_u.xfer(rows[i][43], rows[i][42], rows[i][39:32], rows[i][31:16], nk, rd);
         chk($sformatf("refusal row %0d", i), {15'h0, rows[i][41]}, {15'h0, nk});
         chk($sformatf("data row %0d", i), rows[i][15:0], rd);
      end
      $display("test command table done");
      fault_in = 8'h20;
      cyc(8);
      chk("alert on fault", 16'h0003, {14'h0, alert});
      host_u.xfer(1'b0, 1'b1, 8'h03, 16'h0000, nk, rd);
      host_u.xfer(1'b0, 1'b0, 8'h78, 16'h0000, nk, rd);
      chk("live fault flag", 16'h0020, rd);
      fault_in = 8'h00;
      host_u.xfer(1'b0, 1'b1, 8'h03, 16'h0000, nk, rd);
      host_u.xfer(1'b0, 1'b0, 8'h78, 16'h0000, nk, rd);
      chk("fault flag cleared", 16'h0000, rd);
      chk("controlling alert released", 16'h0002, {14'h0, alert});
      $display("test fault clear done");
      vprog_in = 16'h5800;
      host_u.xfer(1'b0, 1'b1, 8'h3B, 16'h0064, nk, rd);
      cyc(8);
      chk("bus setpoint", 16'h64E6, vout_target);
      chk("fan duty", 16'h0064, {8'h00, fan_duty});
      chk("fan override", 16'h0001, {15'h0, fan_override});
      $display("test setpoint and fan done");
      repeat (4) trip();
      chk("latched", 16'h0001, {15'h0, latched_off});
      chk("off when latched", 16'h0000, {15'h0, main_on});
      hw_on_in = 1'b0;
      cyc(10);
      hw_on_in = 1'b1;
      cyc(10);
      chk("latch released", 16'h0000, {15'h0, latched_off});
      chk("running again", 16'h0001, {15'h0, main_on});
      $display("test retry and latch done");
      srst = 1'b1;
      cyc(2);
      srst = 1'b0;
      cyc(8);
      chk("pin setpoint after reset", 16'h5800, vout_target);
      $display("test second reset done");
      print_verdict();
   end
endmodule

// ### rpc_host_model.sv
`timescale 1ns/1ps
// Host side of the link: one request at a time, each waited out before the next.
module rpc_host_model (
   input  wire logic        lk_clk,
   input  wire logic        lk_done,
   input  wire logic        lk_nack,
   input  wire logic [15:0] lk_rdata,
   output logic             lk_req,
   output logic             lk_wr,
   output logic             lk_side,
   output logic [7:0]       lk_cmd,
   output logic [15:0]      lk_wdata
);
   // Idle lines at time zero.
   initial {lk_req, lk_wr, lk_side, lk_cmd, lk_wdata} = '0;
   // Strobes one request, scrambles the released lines, then takes the answer in its strobe cycle.
   task automatic xfer(input logic sd, input logic wr, input logic [7:0] cmd, input logic [15:0] dat,
                       output logic nk, output logic [15:0] rd);
      int n;
      n = 0;
      // A switch-on first waits out the off time, shortened from two seconds.
      if (wr && cmd == rpc_pkg::CMD_ON_OFF && dat[7:0] == rpc_pkg::ON_OFF_ON) repeat (30) @(posedge lk_clk);
      @(posedge lk_clk);
      #1 {lk_req, lk_wr, lk_side, lk_cmd, lk_wdata} = {1'b1, wr, sd, cmd, dat};
      @(posedge lk_clk);
      #1 {lk_req, lk_cmd, lk_wdata} = {1'b0, ~cmd, ~dat};
      do begin
         @(posedge lk_clk);
         #1 n++;
      end while (lk_done !== 1'b1 && n < 40);
      nk = (lk_done === 1'b1) ? lk_nack : 1'bx;
      rd = lk_rdata;
   endtask
endmodule

// ### rpc_pkg.sv
// Shared constants for the rectifier management command handler.
package rpc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Command codes.
   localparam logic [7:0] CMD_ON_OFF      = 8'h01;
   localparam logic [7:0] CMD_CLR_FAULTS  = 8'h03;
   localparam logic [7:0] CMD_WR_GUARD    = 8'h10;
   localparam logic [7:0] CMD_RESTORE_FAC = 8'h12;
   localparam logic [7:0] CMD_RESTORE_UA  = 8'h16;
   localparam logic [7:0] CMD_STORE_USER  = 8'h17;
   localparam logic [7:0] CMD_RESTORE_U1  = 8'h18;
   localparam logic [7:0] CMD_VOUT_FMT    = 8'h20;
   localparam logic [7:0] CMD_VIN_TURN_ON = 8'h35;
   localparam logic [7:0] CMD_VIN_TURN_OF = 8'h36;
   localparam logic [7:0] CMD_FAN_SETUP   = 8'h3A;
   localparam logic [7:0] CMD_OV_REACTION = 8'h41;
   localparam logic [7:0] CMD_STAT_SUMM   = 8'h78;
   localparam logic [7:0] CMD_STAT_COMM   = 8'h7E;

   ////////////////////////////////////////////////////////////////////////////////
   // Data values and field positions.
   localparam logic [7:0] ON_OFF_ON       = 8'h80;
   localparam logic [7:0] ON_OFF_OFF      = 8'h00;
   localparam logic [7:0] GUARD_NONE      = 8'h00;
   localparam logic [7:0] GUARD_ALL       = 8'h80;
   localparam logic [7:0] GUARD_KEEP_ONOF = 8'h40;
   localparam logic [7:0] VOUT_FMT_VAL    = 8'h17;  // Linear format, exponent -9.
   localparam logic [7:0] FAN_SETUP_VAL   = 8'h00;  // Duty-cycle control of both fans.
   localparam logic [7:0] OV_REACTION_VAL = 8'h80;  // Latch after the retry sequence.
   localparam logic [7:0] FAN_INTERNAL    = 8'h00;
   localparam int         COMM_BAD_CMD    = 7;
   localparam int         COMM_BAD_DATA   = 6;
   localparam int         COMM_OTHER      = 1;
   localparam logic [1:0] RETRY_MAX       = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // Input threshold readbacks in tenths of a volt, per line mode.
   localparam logic [15:0] VIN_ON_HL  = 16'h0384;
   localparam logic [15:0] VIN_OFF_HL = 16'h0320;
   localparam logic [15:0] VIN_ON_LL  = 16'h0384;
   localparam logic [15:0] VIN_OFF_LL = 16'h0320;

   ////////////////////////////////////////////////////////////////////////////////
   // Adjustable settings, highest slot first; slot 0 is the output setpoint, slot 1 the fan duty.
   localparam int NSLOT     = 15;
   localparam int SLOT_VOUT = 0;
   localparam int SLOT_FAN  = 1;
   localparam logic [NSLOT-1:0][7:0] SLOT_CODE = {
      8'h59, 8'h58, 8'h57, 8'h55, 8'h51, 8'h4F, 8'h4A, 8'h48,
      8'h46, 8'h44, 8'h43, 8'h42, 8'h40, 8'h3B, 8'h21};
   localparam logic [NSLOT-1:0][15:0] SLOT_LO = {
      16'h02BC, 16'h0320, 16'h0384, 16'h0384, 16'h0000, 16'h0000, 16'h0000, 16'h0168,
      16'h0000, 16'h4800, 16'h4C00, 16'h5400, 16'h5200, 16'h0000, 16'h5200};
   localparam logic [NSLOT-1:0][15:0] SLOT_HI = {
      16'h0B86, 16'h0B86, 16'h0B86, 16'h0BB8, 16'h05DC, 16'h05DC, 16'h02A1, 16'h0244,
      16'h02A8, 16'h7400, 16'h7400, 16'h7600, 16'h7800, 16'h0064, 16'h7600};
   localparam logic [NSLOT-1:0][15:0] SLOT_DEF = {
      16'h0320, 16'h036B, 16'h0B86, 16'h0BB8, 16'h041A, 16'h044C, 16'h02A1, 16'h019A,
      16'h02A8, 16'h5200, 16'h5400, 16'h7600, 16'h7800, 16'h0000, 16'h6C00};

   ////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int                   CNT_W       = 34;
   localparam longint unsigned      CLK_HZ      = 64'd200000000;
   localparam longint unsigned      RETRY_MS    = 64'd1000;
   localparam longint unsigned      WINDOW_MS   = 64'd60000;
   localparam longint unsigned      MS_PER_S    = 64'd1000;
   localparam logic [CNT_W-1:0]     RETRY_CYC   = CNT_W'(RETRY_MS * CLK_HZ / MS_PER_S);
   localparam logic [CNT_W-1:0]     WINDOW_CYC  = CNT_W'(WINDOW_MS * CLK_HZ / MS_PER_S);

   // Overvoltage retry states.
   typedef enum logic [2:0] {
      OV_RUN   = 3'b001,
      OV_WAIT  = 3'b010,
      OV_LATCH = 3'b100
   } rpc_ov_t;

endpackage
